// file: core/vopc_pkg.sv
// Package: register map, field layout and carrier types of the video output port control
package vopc_pkg;

  // APB address width; registers sit at byte address = 4 * index
  localparam int unsigned APB_AW = 12;

  // Register indices
  localparam logic [7:0] IDX_OUT_FORMAT = 8'h18;
  localparam logic [7:0] IDX_SYNC_WIDTH = 8'h19;
  localparam logic [7:0] IDX_PIN_DISABLE = 8'h1a;
  localparam logic [7:0] IDX_POWER_DOWN = 8'h1b;
  localparam logic [7:0] IDX_TUNING = 8'h1c;
  localparam logic [7:0] IDX_CLAMP = 8'h23;
  localparam logic [7:0] IDX_CRYSTAL = 8'h2b;

  // Values after reset
  localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_SYNC_WIDTH = 8'h10;
  localparam logic [7:0] RST_PIN_DISABLE = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN = 8'h00;
  localparam logic [7:0] RST_TUNING = 8'h47;
  localparam logic [7:0] RST_CLAMP = 8'h08;
  localparam logic [7:0] RST_CRYSTAL = 8'h14;

  // Field positions
  localparam int unsigned OF_BIT_WIDE = 0;
  localparam int unsigned OF_BIT_CLK_RISE = 5;
  localparam int unsigned OF_BIT_FS_LOW = 6;
  localparam int unsigned OF_BIT_LS_LOW = 7;
  localparam int unsigned PD_ADC_MSB = 2;
  localparam int unsigned PD_BIT_PLL = 3;
  localparam int unsigned CLAMP_LSB = 4;
  localparam int unsigned CLAMP_MSB = 6;
  localparam int unsigned DIS_BIT_CLK_A = 6;
  localparam int unsigned DIS_BIT_CLK_B = 7;
  localparam int unsigned NUM_BYTES = 6;

  // Output configuration carried into the pixel clock domain
  typedef struct packed {
    logic clk_rise;
    logic fs_low;
    logic ls_low;
    logic wide;
    logic [7:0] sync_width;
    logic [7:0] pin_disable;
  } vopc_cfg_t;

  localparam vopc_cfg_t CFG_RESET = '{
    clk_rise: RST_OUT_FORMAT[OF_BIT_CLK_RISE],
    fs_low: RST_OUT_FORMAT[OF_BIT_FS_LOW],
    ls_low: RST_OUT_FORMAT[OF_BIT_LS_LOW],
    wide: RST_OUT_FORMAT[OF_BIT_WIDE],
    sync_width: RST_SYNC_WIDTH,
    pin_disable: RST_PIN_DISABLE
  };

  // One pixel from the three converters
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vopc_rgb_t;

  // Output bytes, index 0..5 = red, green, blue, each as primary then secondary byte
  typedef logic [NUM_BYTES-1:0][7:0] vopc_bytes_t;

  // Word address decode of one register
  function automatic logic vopc_hit(input logic [APB_AW-1:0] addr, input logic [7:0] idx);
    return (addr[APB_AW-1:10] == 2'b00) && (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : vopc_hit

endpackage : vopc_pkg

// file: core/vopc_cfg_sync.sv
// Toggle handshake carrying the output configuration into the pixel clock domain
`timescale 1ns/100ps
module vopc_cfg_sync
  import vopc_pkg::*;
(
  // Register side
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire vopc_cfg_t src_cfg,
  // Pixel side
  input wire logic pix_clk,
  input wire logic pix_rst_n,
  output vopc_cfg_t dst_cfg
);

  logic req_reg;
  logic req_next;
  vopc_cfg_t hold_reg;
  vopc_cfg_t hold_next;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic idle;
  logic send;
  logic take;

  // Hold word stays frozen while a toggle is in flight
  assign idle = (req_reg == ack_s2_reg);
  assign send = idle && (src_cfg != hold_reg);
  assign req_next = send ? ~req_reg : req_reg;
  assign hold_next = send ? src_cfg : hold_reg;
  assign take = req_s2_reg ^ req_s3_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_reg <= 1'b0;
      hold_reg <= CFG_RESET;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      hold_reg <= hold_next;
      ack_s1_reg <= req_s3_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      dst_cfg <= CFG_RESET;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      if (take) begin
        dst_cfg <= hold_reg;
      end
    end
  end

endmodule : vopc_cfg_sync

// file: core/vopc_top.sv
// Video output port control: APB registers, pixel output stage and analog control outputs
// Function
// - Clock polarity bit picks output update edge
// - Sync polarity bits: zero high, one low
// - Line sync lasts width register pixel periods
// - Six disable bits three-state six bytes
// - Disable bit overrides every other output setting
// - Either upper disable bit three-states clock
// - Power bits 0-2 stop red/green/blue converters
// - Power bit 3 stops pixel clock PLL
// - Shared three-bit clamp resistance select, zero open
// - Width bit: narrow drives secondary low
`timescale 1ns/100ps
module vopc_top
  import vopc_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pix_clk,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel stream, pix_clk domain
  input wire vopc_rgb_t pix_primary,
  input wire vopc_rgb_t pix_secondary,
  input wire logic pix_line_start,
  input wire logic pix_frame_active,
  // Output pins
  output vopc_bytes_t pix_bus_out,
  output logic [NUM_BYTES-1:0] pix_bus_oe,
  output logic line_sync_output,
  output logic frame_sync_output,
  output logic output_pixel_clock_out,
  output logic output_pixel_clock_oe,
  // Analog controls
  output logic [2:0] adc_power_down,
  output logic pll_power_down,
  output logic [2:0] clamp_resistance_sel,
  output logic [7:0] video_tuning_value,
  output logic [7:0] crystal_trim_value
);

  // Register file
  logic [7:0] out_format_reg;
  logic [7:0] sync_pulse_width_reg;
  logic [7:0] output_pin_disable_reg;
  logic [7:0] power_down_control_reg;
  logic [7:0] video_tuning_reserved_reg;
  logic [7:0] restore_clamp_config_reg;
  logic [7:0] crystal_trim_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic hit_format;
  logic hit_width;
  logic hit_disable;
  logic hit_power;
  logic hit_tuning;
  logic hit_clamp;
  logic hit_crystal;
  logic mapped;
  logic wr_en;
  logic setup;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  assign hit_format = vopc_hit(paddr, IDX_OUT_FORMAT);
  assign hit_width = vopc_hit(paddr, IDX_SYNC_WIDTH);
  assign hit_disable = vopc_hit(paddr, IDX_PIN_DISABLE);
  assign hit_power = vopc_hit(paddr, IDX_POWER_DOWN);
  assign hit_tuning = vopc_hit(paddr, IDX_TUNING);
  assign hit_clamp = vopc_hit(paddr, IDX_CLAMP);
  assign hit_crystal = vopc_hit(paddr, IDX_CRYSTAL);
  assign mapped = hit_format | hit_width | hit_disable | hit_power
                | hit_tuning | hit_clamp | hit_crystal;
  assign wr_en = psel & penable & pwrite & mapped;
  assign setup = psel & ~penable;
  assign wbyte = pwdata[7:0];

  // Read selection; unmapped reads return zero
  assign rd_byte = hit_format ? out_format_reg :
                   hit_width ? sync_pulse_width_reg :
                   hit_disable ? output_pin_disable_reg :
                   hit_power ? power_down_control_reg :
                   hit_tuning ? video_tuning_reserved_reg :
                   hit_clamp ? restore_clamp_config_reg :
                   hit_crystal ? crystal_trim_reg : 8'h00;
  assign prdata_next = setup ? {24'h00_0000, rd_byte} : prdata_reg;

  // Zero wait states; error on unmapped access
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_format_reg <= RST_OUT_FORMAT;
      sync_pulse_width_reg <= RST_SYNC_WIDTH;
      output_pin_disable_reg <= RST_PIN_DISABLE;
      power_down_control_reg <= RST_POWER_DOWN;
      video_tuning_reserved_reg <= RST_TUNING;
      restore_clamp_config_reg <= RST_CLAMP;
      crystal_trim_reg <= RST_CRYSTAL;
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
      if (wr_en && hit_format) out_format_reg <= wbyte;
      if (wr_en && hit_width) sync_pulse_width_reg <= wbyte;
      if (wr_en && hit_disable) output_pin_disable_reg <= wbyte;
      if (wr_en && hit_power) power_down_control_reg <= wbyte;
      if (wr_en && hit_tuning) video_tuning_reserved_reg <= wbyte;
      if (wr_en && hit_clamp) restore_clamp_config_reg <= wbyte;
      if (wr_en && hit_crystal) crystal_trim_reg <= wbyte;
    end
  end

  // Analog control outputs straight from the registers
  assign adc_power_down = power_down_control_reg[PD_ADC_MSB:0];
  assign pll_power_down = power_down_control_reg[PD_BIT_PLL];
  assign clamp_resistance_sel = restore_clamp_config_reg[CLAMP_MSB:CLAMP_LSB];
  assign video_tuning_value = video_tuning_reserved_reg;
  assign crystal_trim_value = crystal_trim_reg;

  // Configuration word handed to the pixel domain
  vopc_cfg_t cfg_src;
  vopc_cfg_t cfg;

  assign cfg_src.clk_rise = out_format_reg[OF_BIT_CLK_RISE];
  assign cfg_src.fs_low = out_format_reg[OF_BIT_FS_LOW];
  assign cfg_src.ls_low = out_format_reg[OF_BIT_LS_LOW];
  assign cfg_src.wide = out_format_reg[OF_BIT_WIDE];
  assign cfg_src.sync_width = sync_pulse_width_reg;
  assign cfg_src.pin_disable = output_pin_disable_reg;

  // Pixel domain reset: asserts at once, releases on pix_clk
  logic pix_rst_s1_reg;
  logic pix_rst_n;

  always_ff @(posedge pix_clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_rst_s1_reg <= 1'b0;
      pix_rst_n <= 1'b0;
    end else begin
      pix_rst_s1_reg <= 1'b1;
      pix_rst_n <= pix_rst_s1_reg;
    end
  end

  // Settings follow software writes; both sides reset to CFG_RESET, the register reset values
  vopc_cfg_sync u_cfg_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .src_cfg(cfg_src),
    .pix_clk(pix_clk),
    .pix_rst_n(pix_rst_n),
    .dst_cfg(cfg)
  );

  // Line sync pulse timing
  logic [7:0] ls_cnt_reg;
  logic [7:0] ls_cnt_next;
  logic ls_act_reg;
  logic ls_act_next;

  // A width of zero yields no pulse; software keeps the minimum
  assign ls_act_next = pix_line_start ? (cfg.sync_width != 8'h00)
                                      : (ls_cnt_reg > 8'h01);
  assign ls_cnt_next = pix_line_start ? cfg.sync_width :
                       (ls_cnt_reg != 8'h00) ? ls_cnt_reg - 8'h01 : 8'h00;

  // Rising-edge output stage
  vopc_bytes_t bytes_next;
  vopc_bytes_t bytes_p_reg;
  vopc_bytes_t bytes_n_reg;
  logic ls_p_reg;
  logic fs_p_reg;
  logic ls_n_reg;
  logic fs_n_reg;
  logic [7:0] sec_red;
  logic [7:0] sec_green;
  logic [7:0] sec_blue;

  // Narrow mode drives the secondary bytes low
  assign sec_red = cfg.wide ? pix_secondary.red : 8'h00;
  assign sec_green = cfg.wide ? pix_secondary.green : 8'h00;
  assign sec_blue = cfg.wide ? pix_secondary.blue : 8'h00;
  assign bytes_next = {sec_blue, pix_primary.blue, sec_green,
                       pix_primary.green, sec_red, pix_primary.red};

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      ls_cnt_reg <= 8'h00;
      ls_act_reg <= 1'b0;
      bytes_p_reg <= '0;
      ls_p_reg <= 1'b0;
      fs_p_reg <= 1'b0;
    end else begin
      ls_cnt_reg <= ls_cnt_next;
      ls_act_reg <= ls_act_next;
      bytes_p_reg <= bytes_next;
      ls_p_reg <= ls_act_next ^ cfg.ls_low;
      fs_p_reg <= pix_frame_active ^ cfg.fs_low;
    end
  end

  // Falling-edge copy, half a period later
  always_ff @(negedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      bytes_n_reg <= '0;
      ls_n_reg <= 1'b0;
      fs_n_reg <= 1'b0;
    end else begin
      bytes_n_reg <= bytes_p_reg;
      ls_n_reg <= ls_p_reg;
      fs_n_reg <= fs_p_reg;
    end
  end

  // Edge select between the two flop stages
  assign pix_bus_out = cfg.clk_rise ? bytes_p_reg : bytes_n_reg;
  assign line_sync_output = cfg.clk_rise ? ls_p_reg : ls_n_reg;
  assign frame_sync_output = cfg.clk_rise ? fs_p_reg : fs_n_reg;

  // Three-state controls win over width and format settings
  assign pix_bus_oe = ~cfg.pin_disable[NUM_BYTES-1:0];
  assign output_pixel_clock_out = pix_clk;
  assign output_pixel_clock_oe = ~(cfg.pin_disable[DIS_BIT_CLK_A]
                                 | cfg.pin_disable[DIS_BIT_CLK_B]);

  // Helper for pulse width check
  logic [7:0] run_reg;
  logic [7:0] wseen_reg;

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      run_reg <= 8'h00;
      wseen_reg <= 8'h00;
    end else begin
      run_reg <= pix_line_start ? 8'h00 : run_reg + {7'h00, ls_act_reg};
      if (pix_line_start) wseen_reg <= cfg.sync_width;
    end
  end

  // Checks
  edge_rise_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (cfg.clk_rise && $stable(cfg)) |-> (line_sync_output == $past(ls_act_next ^ cfg.ls_low)))
    else $error("line sync not updated on rising edge");

  edge_fall_a: assert property (
    @(negedge pix_clk) disable iff (!pix_rst_n)
    !cfg.clk_rise |-> (pix_bus_out == $past(bytes_p_reg)))
    else $error("pixel data not updated on falling edge");

  sync_polarity_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (cfg.clk_rise && $stable(cfg.ls_low))
      |-> (line_sync_output == (ls_act_reg ^ cfg.ls_low)))
    else $error("line sync polarity wrong");

  frame_polarity_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (cfg.clk_rise && $stable(cfg.fs_low))
      |-> (frame_sync_output == ($past(pix_frame_active) ^ cfg.fs_low)))
    else $error("frame sync polarity wrong");

  pulse_width_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    ($fell(ls_act_reg) && !$past(pix_line_start)) |-> (run_reg == wseen_reg))
    else $error("line sync width differs from register");

  pulse_start_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (pix_line_start && cfg.sync_width != 8'h00) |=> ls_act_reg)
    else $error("line sync did not start");

  byte_disable_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    pix_bus_oe == ~cfg.pin_disable[NUM_BYTES-1:0])
    else $error("byte enable does not follow disable bits");

  clock_disable_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (cfg.pin_disable[DIS_BIT_CLK_A] || cfg.pin_disable[DIS_BIT_CLK_B])
      == !output_pixel_clock_oe)
    else $error("pixel clock enable wrong");

  adc_power_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_en && hit_power) |=> (adc_power_down == $past(pwdata[2:0])))
    else $error("converter power-down not taken");

  pll_power_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_en && hit_power) |=> (pll_power_down == $past(pwdata[3])))
    else $error("PLL power-down not taken");

  clamp_select_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_en && hit_clamp) |=> (clamp_resistance_sel == $past(pwdata[6:4])))
    else $error("clamp select not taken");

  narrow_low_a: assert property (
    @(posedge pix_clk) disable iff (!pix_rst_n)
    (!cfg.wide && $stable(cfg.wide))
      |-> (pix_bus_out[1] == 8'h00 && pix_bus_out[3] == 8'h00 && pix_bus_out[5] == 8'h00))
    else $error("secondary bytes not low in narrow mode");

  cfg_apply_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $changed(output_pin_disable_reg)
      |-> ##[1:16] (pix_bus_oe == ~output_pin_disable_reg[NUM_BYTES-1:0]))
    else $error("disable setting did not reach the pins");

endmodule : vopc_top

// file: verification/vopc_sink.sv
// Downstream pixel sink model: resolves the output pins and measures line sync pulses
`timescale 1ns/100ps
module vopc_sink
  import vopc_pkg::*;
(
  // Pins from the port
  input wire vopc_bytes_t bus_out,
  input wire logic [NUM_BYTES-1:0] bus_oe,
  input wire logic clk_out,
  input wire logic clk_oe,
  input wire logic line_sync,
  // Sink setup
  input wire logic rise_mode,
  input wire logic ls_low,
  // Observed values
  output vopc_bytes_t wire_bytes,
  output logic [7:0] pulse_len
);
  logic clk_wire;
  logic [7:0] cnt = 8'h00;
  logic [7:0] len = 8'h00;

  // Data pins have pull-downs, so a released byte reads zero
  always_comb begin
    for (int i = 0; i < NUM_BYTES; i++) begin
      wire_bytes[i] = bus_oe[i] ? bus_out[i] : 8'h00;
    end
  end
  assign clk_wire = clk_oe ? clk_out : 1'b0;
  assign pulse_len = len;

  // Count sampling edges while line sync is active, on the edge opposite to the update edge
  always @(posedge clk_wire or negedge clk_wire) begin
    if (clk_wire != rise_mode) begin
      if ((line_sync ^ ls_low) === 1'b1) begin
        cnt = cnt + 8'h01;
      end else if (cnt != 8'h00) begin
        len = cnt;
        cnt = 8'h00;
      end
    end
  end
endmodule : vopc_sink

// file: verification/test_video_output_port_control.sv
// Testbench of the video output port control: APB register tests and pin checks
`timescale 1ns/100ps
module test_video_output_port_control
  import vopc_pkg::*;
;
  localparam logic [7:0] IDX_TAB [7] = '{IDX_OUT_FORMAT, IDX_SYNC_WIDTH, IDX_PIN_DISABLE,
    IDX_POWER_DOWN, IDX_TUNING, IDX_CLAMP, IDX_CRYSTAL};
  localparam logic [7:0] RST_TAB [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h47, 8'h08, 8'h14};
  logic ref_clk, reset_n, pix_clk, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  vopc_rgb_t pix_primary, pix_secondary;
  logic pix_line_start, pix_frame_active, line_sync_output, frame_sync_output;
  vopc_bytes_t pix_bus_out, wire_bytes;
  logic [NUM_BYTES-1:0] pix_bus_oe;
  logic output_pixel_clock_out, output_pixel_clock_oe, pll_power_down, err;
  logic [2:0] adc_power_down, clamp_resistance_sel;
  logic [7:0] video_tuning_value, crystal_trim_value, pulse_len;
  logic rise_mode, ls_low;
  int fails, n_tests;

  vopc_top dut_u (.ref_clk, .reset_n, .pix_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pix_primary, .pix_secondary, .pix_line_start,
    .pix_frame_active, .pix_bus_out, .pix_bus_oe, .line_sync_output, .frame_sync_output,
    .output_pixel_clock_out, .output_pixel_clock_oe, .adc_power_down, .pll_power_down,
    .clamp_resistance_sel, .video_tuning_value, .crystal_trim_value);
  vopc_sink sink_u (.bus_out(pix_bus_out), .bus_oe(pix_bus_oe), .clk_out(output_pixel_clock_out),
    .clk_oe(output_pixel_clock_oe), .line_sync(line_sync_output), .rise_mode(rise_mode),
    .ls_low(ls_low), .wire_bytes(wire_bytes), .pulse_len(pulse_len));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    pix_clk = 1'b0;
    #3.3;
    forever #7.5 pix_clk = ~pix_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [APB_AW-1:0] addr, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, {24'h00_0000, d});
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000);
    check(name, rd, {24'h00_0000, exp});
  endtask : rd_chk

  // Lets a new setting cross into the pixel domain
  task automatic settle();
    repeat (20) @(posedge ref_clk);
  endtask : settle

  task automatic line_pulse(input logic [7:0] exp);
    @(posedge pix_clk);
    pix_line_start <= 1'b1;
    @(posedge pix_clk);
    pix_line_start <= 1'b0;
    repeat (40) @(posedge pix_clk);
    check("line sync length", 32'(pulse_len), 32'(exp));
  endtask : line_pulse

  // New pixel and frame sync, seen just after the rising and the falling edge
  task automatic edge_chk(input logic rise, input logic wide);
    @(posedge pix_clk);
    pix_primary <= 24'h00_0000;
    pix_secondary <= 24'h00_0000;
    pix_frame_active <= 1'b0;
    repeat (4) @(posedge pix_clk);
    pix_primary <= 24'h5a_c3e1;
    pix_secondary <= 24'h96_7b2d;
    pix_frame_active <= 1'b1;
    @(posedge pix_clk);
    #2;
    check("data after rise", 32'(pix_bus_out[0]), rise ? 32'h5a : 32'h00);
    check("frame after rise", 32'(frame_sync_output), 32'(rise));
    @(negedge pix_clk);
    #2;
    check("data after fall", 32'(pix_bus_out[4]), 32'h0000_00e1);
    check("secondary red", 32'(pix_bus_out[1]), wide ? 32'h96 : 32'h00);
    check("secondary blue", 32'(pix_bus_out[5]), wide ? 32'h2d : 32'h00);
    check("frame after fall", 32'(frame_sync_output), 32'h0000_0001);
    @(posedge pix_clk);
    pix_frame_active <= 1'b0;
  endtask : edge_chk

  initial begin
    #500000;
    fails++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pix_line_start, pix_frame_active} = '0;
    {pix_primary, pix_secondary, reset_n, rise_mode, ls_low, rd, err} = '0;
    fails = 0;
    n_tests = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset value", IDX_TAB[i], RST_TAB[i]);
    end
    check("analog reset", 32'({pll_power_down, adc_power_down, clamp_resistance_sel}), 32'h0);
    check("enables reset", 32'({output_pixel_clock_oe, pix_bus_oe}), 32'h7f);
    $display("test reset values done");
    apb(1'b1, 12'h074, 32'h0000_0055);
    apb(1'b0, 12'h074, 32'h0000_0000);
    check("unmapped read", {rd[31:1], err}, 32'h0000_0001);
    apb(1'b1, 12'h071, 32'h0000_0055);
    check("misaligned error", 32'(err), 32'h0000_0001);
    rd_chk("tuning kept", IDX_TUNING, 8'h47);
    $display("test unmapped access done");
    wr(IDX_TUNING, 8'h49);
    wr(IDX_CRYSTAL, 8'ha5);
    check("analog bytes", 32'({video_tuning_value, crystal_trim_value}), 32'h0000_49a5);
    for (int b = 0; b < 4; b++) begin
      wr(IDX_POWER_DOWN, 8'(1 << b));
      check("power out", 32'({pll_power_down, adc_power_down}), 32'(1 << b));
    end
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CLAMP, 8'(c * 16 + 8));
      check("clamp out", 32'(clamp_resistance_sel), 32'(c));
      rd_chk("clamp reg", IDX_CLAMP, 8'(c * 16 + 8));
    end
    $display("test analog controls done");
    edge_chk(1'b0, 1'b0);
    wr(IDX_OUT_FORMAT, 8'h21);
    settle();
    rise_mode <= 1'b1;
    edge_chk(1'b1, 1'b1);
    $display("test edge and width done");
    line_pulse(8'h10);
    wr(IDX_OUT_FORMAT, 8'hc1);
    wr(IDX_SYNC_WIDTH, 8'h02);
    settle();
    rise_mode <= 1'b0;
    ls_low <= 1'b1;
    check("idle low syncs", 32'({line_sync_output, frame_sync_output}), 32'h3);
    line_pulse(8'h02);
    wr(IDX_OUT_FORMAT, 8'h00);
    wr(IDX_SYNC_WIDTH, 8'h01);
    settle();
    ls_low <= 1'b0;
    check("idle high syncs", 32'({line_sync_output, frame_sync_output}), 32'h0);
    line_pulse(8'h01);
    $display("test sync pulses done");
    wr(IDX_OUT_FORMAT, 8'h01);
    @(posedge pix_clk);
    pix_primary <= 24'hff_ffff;
    pix_secondary <= 24'hff_ffff;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_PIN_DISABLE, 8'(1 << i));
      settle();
      check("byte enables", 32'(pix_bus_oe), 32'(~(1 << i) & 8'h3f));
      check("clock enable", 32'(output_pixel_clock_oe), 32'(i < 6));
      check("released byte", 32'(wire_bytes[i % 6]), i < 6 ? 32'h00 : 32'hff);
    end
    $display("test output disable done");
    conclude();
  end
endmodule : test_video_output_port_control
